// >>> hdl/cprf_record_formatter.sv
`timescale 1ns/1ps
`include "cprf_regs.svh"
module cprf_record_formatter
	import cprf_pkg::*;
(
	// clock and reset
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_rst_b,
	// configuration
	input  wire logic                 i_streamout_en,
	// hevc pu statistics in
	input  wire logic                 i_pu_valid,
	input  wire cprf_pu_stat_t        i_pu_stat,
	// hevc tile statistics in
	input  wire logic                 i_tile_valid,
	input  wire cprf_tile_stat_t      i_tile_stat,
	// vp9 block statistics in
	input  wire logic                 i_blk_valid,
	input  wire cprf_blk_stat_t       i_blk_stat,
	// cu input record in
	input  wire logic                 i_cu_valid,
	input  wire logic [31:0]          i_cu_dw6,
	input  wire logic [31:0]          i_cu_dw7,
	// hevc pu stream-out line
	output logic                      o_pu_line_valid,
	output logic [511:0]              o_pu_line,
	// hevc tile stream-out line
	output logic                      o_tile_valid,
	output logic [127:0]              o_tile_rec,
	// vp9 block stream-out record
	output logic                      o_blk_valid,
	output logic [63:0]               o_blk_rec,
	output logic                      o_sb_done,
	// decoded cu record
	output logic                      o_cu_valid,
	output cprf_cu_dec_t              o_cu_dec
);
	// ***********************************
	// hevc quarter-line packing
	// ***********************************
	logic [127:0] q_rec;
	logic [511:0] line_r;
	logic [1:0]   qidx_r;
	logic [1:0]   qidx_nxt;
	logic         line_done;
	// quarter record, reserved bits zero
	always_comb begin
		q_rec = '0;                                                 // [R23]
		q_rec[`CPRF_Q_SKIP] = i_pu_stat.skip;                       // [R3]
		q_rec[`CPRF_Q_SB_EXCEED] = i_pu_stat.sb_exceed;             // [R4]
		q_rec[`CPRF_Q_CBF_LO +: 48] = i_pu_stat.cbf;                // [R3]
		q_rec[`CPRF_Q_COEF_LO +: 18] = i_pu_stat.coef_bits;         // [R5]
		q_rec[`CPRF_Q_PU_LO +: 18] = i_pu_stat.pu_bits;             // [R6]
	end
	// quarter slot advance and line completion
	assign line_done = i_streamout_en && i_pu_valid && (qidx_r == 2'(`CPRF_QUARTERS - 1)); // [R2]
	assign qidx_nxt  = (i_streamout_en && i_pu_valid) ? qidx_r + 2'h1 : qidx_r;
	// gather four quarters into one line
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			qidx_r          <= 2'h0;
			line_r          <= '0;
			o_pu_line_valid <= 1'b0;
			o_pu_line       <= '0;
		end else begin
			qidx_r          <= i_streamout_en ? qidx_nxt : 2'h0;  // [R1]
			o_pu_line_valid <= line_done;                          // [R1]
			if (i_streamout_en && i_pu_valid) begin
				line_r[qidx_r*128 +: 128] <= q_rec;                // [R2]
			end
			if (line_done) begin
				o_pu_line <= {q_rec, line_r[383:0]};               // [R2]
			end
		end
	end
	// ***********************************
	// hevc tile record
	// ***********************************
	logic [127:0] tile_rec;
	always_comb begin
		tile_rec = '0;                                              // [R8]
		tile_rec[31:0] = i_tile_stat.bit_count;                     // [R7]
		tile_rec[`CPRF_T_POSX_LO +: 16] = i_tile_stat.pos_x;        // [R8]
		tile_rec[`CPRF_T_POSY_LO +: 16] = i_tile_stat.pos_y;        // [R8]
	end
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_tile_valid <= 1'b0;
			o_tile_rec   <= '0;
		end else begin
			o_tile_valid <= i_streamout_en && i_tile_valid;         // [R1]
			if (i_streamout_en && i_tile_valid) begin
				o_tile_rec <= tile_rec;
			end
		end
	end
	// ***********************************
	// vp9 block record
	// ***********************************
	logic [63:0] blk_rec;
	logic [5:0]  rec_cnt_r;
	logic        sb_last;
	logic        blk_take;
	always_comb begin
		blk_rec = '0;
		blk_rec[`CPRF_V_SKIP_LO +: 4] = i_blk_stat.skip;                       // [R9]
		blk_rec[`CPRF_V_MODE_LO +: 8] = i_blk_stat.inter_motion_mode;          // [R10]
		blk_rec[`CPRF_V_NZ_LO +: 13] = i_blk_stat.nz_count;                    // [R11]
		blk_rec[`CPRF_V_CBITS_LO +: 16] = i_blk_stat.coefficient_bit_total;    // [R12]
		blk_rec[`CPRF_V_BBITS_LO +: 16] = i_blk_stat.block_bit_total;          // [R13]
	end
	// partial superblocks still emit all slots; absent 8x8s come in as zero records
	assign blk_take = i_streamout_en && i_blk_valid;                           // [R15]
	assign sb_last  = blk_take && (rec_cnt_r == 6'(`CPRF_SB_RECORDS - 1));     // [R14]
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_blk_valid <= 1'b0;
			o_blk_rec   <= '0;
			o_sb_done   <= 1'b0;
			rec_cnt_r   <= 6'h0;
		end else begin
			o_blk_valid <= blk_take;                                           // [R1]
			o_sb_done   <= sb_last;                                            // [R14]
			if (blk_take) begin
				o_blk_rec <= blk_rec;
				rec_cnt_r <= rec_cnt_r + 6'h1;                                 // [R14]
			end else if (!i_streamout_en) begin
				rec_cnt_r <= 6'h0;
			end
		end
	end
	// ***********************************
	// cu input record decode
	// ***********************************
	cprf_cu_dec_t cu_dec;
	logic [2:0]   chroma_raw;
	logic [3:0]   tuc_m1;
	assign chroma_raw = i_cu_dw7[`CPRF_DW7_CHROMA_LO +: 3];                    // [R22]
	assign tuc_m1     = i_cu_dw6[`CPRF_DW6_TUC_LO +: 4];                       // [R17]
	always_comb begin
		cu_dec = '0;
		cu_dec.qp_sign   = i_cu_dw7[`CPRF_DW7_QP_SIGN];                        // [R18]
		cu_dec.qp_mag    = i_cu_dw7[`CPRF_DW7_QP_LO +: 7];                     // [R18]
		// positive values above the top of range are flagged
		cu_dec.qp_valid  = i_cu_dw7[`CPRF_DW7_QP_SIGN] ||
			(i_cu_dw7[`CPRF_DW7_QP_LO +: 7] <= `CPRF_QP_MAX);               // [R18]
		cu_dec.zero_coef = i_cu_dw7[`CPRF_DW7_ZERO];                           // [R19]
		cu_dec.raw_pcm_select = i_cu_dw7[`CPRF_DW7_PCM];                       // [R20]
		cu_dec.last_cu   = i_cu_dw7[`CPRF_DW7_LAST];                           // [R21]
		// raw pcm overrides prediction kind
		cu_dec.prediction_kind = i_cu_dw7[`CPRF_DW7_PRED] && !i_cu_dw7[`CPRF_DW7_PCM]; // [R20]
		cu_dec.chroma_mode  = chroma_raw;                                      // [R22]
		cu_dec.chroma_valid = (chroma_raw != CPRF_CH_RSVD) && (chroma_raw <= CPRF_CH_DC); // [R22]
		cu_dec.transform_count = {1'b0, tuc_m1} + 5'h1;                        // [R17]
	end
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_cu_valid <= 1'b0;
			o_cu_dec   <= '0;
		end else begin
			o_cu_valid <= i_cu_valid;                                          // [R16]
			if (i_cu_valid) begin
				o_cu_dec <= cu_dec;
			end
		end
	end
endmodule // cprf_record_formatter

// >>> common/cprf_regs.svh
`ifndef CPRF_REGS_SVH
`define CPRF_REGS_SVH
// Overview of operation
// [R1] stream-out records are written only while the stream-out enable is set
// [R2] each hevc stream-out line holds four quarter lines, one pu each
// [R3] pu skip flag at bit 0, 48-bit cbf at bits 63:16
// [R4] superblock exceed flag at bit 1, meaningful on final pu only
// [R5] 18-bit residual coefficient bit count at bits 81:64
// [R6] 18-bit pu syntax bit count at bits 113:96
// [R7] 32-bit tile bit count at bits 31:0, header data and tail
// [R8] tile x at 79:64, y at 95:80, zeros at 63:32 and 127:96
// [R9] vp9 record: per-4x4 skip flags in bits 3:0, down to 8x8
// [R10] two-bit inter motion mode per 4x4 in bits 11:4
// [R11] 13-bit non-zero coefficient count at bits 28:16
// [R12] 16-bit coefficient bit total at bits 47:32
// [R13] block bit total at bits 63:48
// [R14] vp9 superblock is 64x64 only, 64 records per superblock
// [R15] partial superblocks at frame edge accepted down to 8x8
// [R16] software lays cu records as cache-aligned double words
// [R17] transform count minus one in dw6 27:24, at most 16
// [R18] quantiser sign bit 31, magnitude 30:24, range ends at 51
// [R19] dw7 bit 23 forces all cu coefficients to zero
// [R20] bit 22 selects raw pcm and overrides prediction kind
// [R21] software sets bit 21 only on final cu of the largest unit
// [R22] chroma intra mode 10:8 decode, code 1 reserved
// [R23] reserved quarter-line bits are written as zero
`define CPRF_Q_SKIP         0
`define CPRF_Q_SB_EXCEED    1
`define CPRF_Q_CBF_LO       16
`define CPRF_Q_COEF_LO      64
`define CPRF_Q_PU_LO        96
`define CPRF_T_POSX_LO      64
`define CPRF_T_POSY_LO      80
`define CPRF_V_SKIP_LO      0
`define CPRF_V_MODE_LO      4
`define CPRF_V_NZ_LO        16
`define CPRF_V_CBITS_LO     32
`define CPRF_V_BBITS_LO     48
`define CPRF_QUARTERS       4
`define CPRF_SB_RECORDS     64
`define CPRF_DW7_QP_SIGN    31
`define CPRF_DW7_QP_LO      24
`define CPRF_DW7_ZERO       23
`define CPRF_DW7_PCM        22
`define CPRF_DW7_LAST       21
`define CPRF_DW7_PRED       15
`define CPRF_DW7_CHROMA_LO  8
`define CPRF_DW6_TUC_LO     24
`define CPRF_QP_MAX         7'h33
`endif

// >>> common/cprf_pkg.sv
package cprf_pkg;
	typedef struct packed {
		logic        skip;
		logic        sb_exceed;
		logic [47:0] cbf;
		logic [17:0] coef_bits;
		logic [17:0] pu_bits;
	} cprf_pu_stat_t;
	typedef struct packed {
		logic [31:0] bit_count;
		logic [15:0] pos_x;
		logic [15:0] pos_y;
	} cprf_tile_stat_t;
	typedef struct packed {
		logic [3:0]  skip;
		logic [7:0]  inter_motion_mode;
		logic [12:0] nz_count;
		logic [15:0] coefficient_bit_total;
		logic [15:0] block_bit_total;
	} cprf_blk_stat_t;
	typedef enum logic [2:0] {
		CPRF_CH_DERIVED = 3'h0, CPRF_CH_RSVD = 3'h1, CPRF_CH_PLANAR = 3'h2,
		CPRF_CH_VERT = 3'h3, CPRF_CH_HORZ = 3'h4, CPRF_CH_DC = 3'h5
	} cprf_chroma_t;
	typedef struct packed {
		logic        qp_sign;
		logic [6:0]  qp_mag;
		logic        zero_coef;
		logic        raw_pcm_select;
		logic        last_cu;
		logic        prediction_kind;
		logic [2:0]  chroma_mode;
		logic        chroma_valid;
		logic        qp_valid;
		logic [4:0]  transform_count;
	} cprf_cu_dec_t;
endpackage

// >>> test/cprf_sw_model.sv
`timescale 1ns/1ps
// ****************
// software filling the cu record surface
// ****************
module cprf_sw_model (
	// record select and noise
	input  wire logic [3:0]  i_idx,
	input  wire logic [31:0] i_rnd,
	// double words 6 and 7
	output logic      [31:0] o_dw6,
	output logic      [31:0] o_dw7
);
	logic [6:0] mag;
	// quantiser kept within 0..51, sign clear as for 8-bit content
	assign mag = (i_rnd[29:24] > 6'h33) ? {1'b0, i_rnd[29:24] - 6'h0c} : {1'b0, i_rnd[29:24]};
	// transform count minus one never above 15
	assign o_dw6 = {4'h0, i_idx, i_rnd[23:0]};
	// last cu flag only on the final record
	assign o_dw7 = {1'b0, mag, i_rnd[23:22], i_idx == 4'hf, i_rnd[20:11], i_idx[2:0], i_rnd[7:0]};
endmodule // cprf_sw_model

// >>> test/cprf_record_formatter_asserts.sv
`timescale 1ns/1ps
module cprf_chk
	import cprf_pkg::*;
(
	// clock, reset, enable
	input wire logic         i_clk_sys,
	input wire logic         i_rst_b,
	input wire logic         i_streamout_en,
	// requests
	input wire logic         i_tile_valid,
	input wire logic         i_blk_valid,
	input wire logic         i_cu_valid,
	input wire logic [31:0]  i_cu_dw6,
	// results
	input wire logic         o_pu_line_valid,
	input wire logic [511:0] o_pu_line,
	input wire logic         o_tile_valid,
	input wire logic [127:0] o_tile_rec,
	input wire logic         o_blk_valid,
	input wire logic [63:0]  o_blk_rec,
	input wire logic         o_sb_done,
	input wire logic         o_cu_valid,
	input wire cprf_cu_dec_t o_cu_dec
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	a_pu_gated: assert property (!i_streamout_en |=> !o_pu_line_valid) else $error("pu line while off");
	a_stat_gated: assert property (!i_streamout_en |=> !o_tile_valid && !o_blk_valid) else $error("stat while off");
	a_tile_next: assert property (i_tile_valid && i_streamout_en |=> o_tile_valid) else $error("tile late");
	a_tile_zero: assert property (o_tile_valid |-> o_tile_rec[63:32] == 0 && o_tile_rec[127:96] == 0) else $error("tile rsvd");
	a_blk_next: assert property (i_blk_valid && i_streamout_en |=> o_blk_valid) else $error("blk late");
	a_blk_rsvd: assert property (o_blk_valid |-> o_blk_rec[15:12] == 0 && o_blk_rec[31:29] == 0) else $error("blk rsvd");
	a_sb_with: assert property (o_sb_done |-> o_blk_valid) else $error("sb done alone");
	a_cu_count: assert property (i_cu_valid |=> o_cu_valid && o_cu_dec.transform_count == $past(i_cu_dw6[27:24]) + 5'h1) else $error("tu count");
	a_pcm_pred: assert property (o_cu_valid && o_cu_dec.raw_pcm_select |-> !o_cu_dec.prediction_kind) else $error("pcm pred");
	a_pu_rsvd: assert property (o_pu_line_valid |-> o_pu_line[15:2] == 0 && o_pu_line[127:114] == 0 && o_pu_line[511:498] == 0) else $error("pu rsvd");
	c_tile: cover property (o_tile_valid);
	c_pu: cover property (o_pu_line_valid);
	c_sb: cover property (o_sb_done);
	c_pcm: cover property (o_cu_valid && o_cu_dec.raw_pcm_select);
endmodule // cprf_chk
bind cprf_record_formatter cprf_chk u_cprf_chk (.i_clk_sys, .i_rst_b, .i_streamout_en, .i_tile_valid, .i_blk_valid, .i_cu_valid, .i_cu_dw6, .o_pu_line_valid, .o_pu_line, .o_tile_valid, .o_tile_rec, .o_blk_valid, .o_blk_rec, .o_sb_done, .o_cu_valid, .o_cu_dec);

// >>> test/test_cprf_record_formatter.sv
`timescale 1ns/1ps
module test_cprf_record_formatter;
	import cprf_pkg::*;
	logic            i_clk_sys = 0, i_rst_b = 0, i_streamout_en = 0;
	logic            i_pu_valid = 0, i_tile_valid = 0, i_blk_valid = 0, i_cu_valid = 0;
	cprf_pu_stat_t   i_pu_stat = '0, p;
	cprf_tile_stat_t i_tile_stat = '0, t;
	cprf_blk_stat_t  i_blk_stat = '0, b;
	cprf_cu_dec_t    o_cu_dec, d;
	logic [3:0]      idx = 0;
	logic [31:0]     rnd = 0, i_cu_dw6, i_cu_dw7;
	logic            o_pu_line_valid, o_tile_valid, o_blk_valid, o_sb_done, o_cu_valid;
	logic [511:0]    o_pu_line, ln, qpu[$], qt[$], qb[$], qc[$];
	logic [127:0]    o_tile_rec;
	logic [63:0]     o_blk_rec;
	logic [95:0]     r;
	int              errors = 0, samples_checked = 0, k = 0, c = 0;
	always #12.5 i_clk_sys = ~i_clk_sys;
	cprf_record_formatter u_cprf_record_formatter (.i_clk_sys, .i_rst_b, .i_streamout_en,
		.i_pu_valid, .i_pu_stat, .i_tile_valid, .i_tile_stat, .i_blk_valid, .i_blk_stat,
		.i_cu_valid, .i_cu_dw6, .i_cu_dw7, .o_pu_line_valid, .o_pu_line, .o_tile_valid,
		.o_tile_rec, .o_blk_valid, .o_blk_rec, .o_sb_done, .o_cu_valid, .o_cu_dec);
	cprf_sw_model u_cprf_sw_model (.i_idx(idx), .i_rnd(rnd), .o_dw6(i_cu_dw6), .o_dw7(i_cu_dw7));
	// ****************
	// compare and report
	// ****************
	task chk(input string n, input logic [511:0] e, input logic [511:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task end_sim;
		$display("errors %0d checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// watcher: oldest note against each result
	always @(negedge i_clk_sys) begin
		if (o_pu_line_valid) chk("pu", qpu.size() ? qpu.pop_front() : 'x, o_pu_line);
		if (o_tile_valid) chk("tile", qt.size() ? qt.pop_front() : 'x, o_tile_rec);
		if (o_blk_valid) chk("blk", qb.size() ? qb.pop_front() : 'x, {o_sb_done, o_blk_rec});
		if (o_cu_valid) chk("cu", qc.size() ? qc.pop_front() : 'x, o_cu_dec);
	end
	// ****************
	// drivers
	// ****************
	task pu(input int n, input bit en);
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk_sys);
			r = {$urandom, $urandom, $urandom};
			p = r[85:0];
			i_streamout_en <= en;
			i_pu_valid <= 1;
			i_pu_stat <= p;
			ln[128*k +: 128] = {14'h0, p.pu_bits, 14'h0, p.coef_bits, p.cbf, 14'h0, p.sb_exceed, p.skip};
			k = en ? (k + 1) % 4 : 0;
			if (en && k == 0) qpu.push_back(ln);
		end
		@(posedge i_clk_sys) i_pu_valid <= 0;
	endtask
	task ts(input int n, input bit en);
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk_sys);
			r = {$urandom, $urandom, $urandom};
			t = r[63:0];
			b = r[95:39];
			i_streamout_en <= en;
			i_tile_valid <= 1;
			i_blk_valid <= 1;
			i_tile_stat <= t;
			i_blk_stat <= b;
			c = en ? (c + 1) % 64 : 0;
			if (en) qt.push_back({32'h0, t.pos_y, t.pos_x, 32'h0, t.bit_count});
			if (en) qb.push_back({c == 0, b.block_bit_total, b.coefficient_bit_total, 3'h0,
				b.nz_count, 4'h0, b.inter_motion_mode, b.skip});
		end
		@(posedge i_clk_sys);
		i_tile_valid <= 0;
		i_blk_valid <= 0;
	endtask
	task cu;
		for (int i = 0; i < 16; i++) begin
			@(posedge i_clk_sys);
			idx <= i[3:0];
			rnd <= $urandom;
			i_cu_valid <= 1;
			#1;
			d = {i_cu_dw7[31:21], i_cu_dw7[15] & ~i_cu_dw7[22], i_cu_dw7[10:8],
				i_cu_dw7[10:8] != 3'h1 && i_cu_dw7[10:8] < 3'h6,
				i_cu_dw7[31] || i_cu_dw7[30:24] <= 7'h33, {1'b0, i_cu_dw6[27:24]} + 5'h1};
			qc.push_back(d);
		end
		@(posedge i_clk_sys) i_cu_valid <= 0;
	endtask
	initial begin
		repeat (100000) @(posedge i_clk_sys);
		errors++;
		end_sim;
	end
	initial begin
		void'($urandom(61794));
		repeat (2) @(posedge i_clk_sys);
		i_rst_b <= 1;
		pu(2, 1);
		pu(3, 0);
		pu(8, 1);
		ts(10, 1);
		ts(2, 0);
		cu;
		ts(70, 1);
		repeat (4) @(posedge i_clk_sys);
		chk("left", 0, qpu.size() + qt.size() + qb.size() + qc.size());
		end_sim;
	end
endmodule // test_cprf_record_formatter
